// file: rtl/cibs_pkg.sv
// Package for the charger input and battery switch configuration registers.
// Assumes a byte-wide register access port driven by the serial host logic.
package cibs_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] INPUT_PROTECT_BOOST_DPM_CFG_ADDR = 8'h06;
  localparam logic [7:0] TIMER_BATTERY_SWITCH_CFG_ADDR    = 8'h07;
  localparam logic [7:0] INPUT_PROTECT_BOOST_DPM_CFG_RST  = 8'he6;
  localparam logic [7:0] TIMER_BATTERY_SWITCH_CFG_RST     = 8'h4c;
  localparam logic [7:0] UNMAPPED_READ_VALUE              = 8'h00;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int OVP_SEL_LSB       = 6;
  localparam int BOOST_SEL_LSB     = 4;
  localparam int VINR_CODE_LSB     = 0;
  localparam int DETECT_TRIG_BIT   = 7;
  localparam int HALF_RATE_EN_BIT  = 6;
  localparam int BATSW_DISABLE_BIT = 5;
  localparam int WARM_VSEL_BIT     = 4;
  localparam int BATSW_DLY_BIT     = 3;
  localparam int BATSW_RST_EN_BIT  = 2;
  localparam int TRACK_SEL_LSB     = 0;
  // Fields of 0x07 kept on watchdog expiry
  localparam logic [7:0] WDOG_KEEP_MASK = 8'h28;

  // ********************************************************************
  // Voltages in millivolts
  // ********************************************************************
  localparam logic [15:0] OVP_MV_0      = 16'h157c; // 5500
  localparam logic [15:0] OVP_MV_1      = 16'h1964; // 6500
  localparam logic [15:0] OVP_MV_2      = 16'h2904; // 10500
  localparam logic [15:0] OVP_MV_3      = 16'h36b0; // 14000
  localparam logic [15:0] BOOST_MV_0    = 16'h12f2; // 4850
  localparam logic [15:0] BOOST_MV_1    = 16'h1388; // 5000
  localparam logic [15:0] BOOST_MV_2    = 16'h141e; // 5150
  localparam logic [15:0] BOOST_MV_3    = 16'h14b4; // 5300
  localparam logic [15:0] VINR_OFS_MV_0 = 16'h0f3c; // 3900
  localparam logic [15:0] VINR_OFS_MV_1 = 16'h170c; // 5900
  localparam logic [15:0] VINR_OFS_MV_2 = 16'h1d4c; // 7500
  localparam logic [15:0] VINR_OFS_MV_3 = 16'h2904; // 10500
  localparam logic [15:0] VINR_STEP_MV  = 16'h0064; // 100
  localparam logic [15:0] TRACK_MV_1    = 16'h00c8; // 200
  localparam logic [15:0] TRACK_MV_2    = 16'h00fa; // 250
  localparam logic [15:0] TRACK_MV_3    = 16'h012c; // 300
  localparam logic [15:0] WARM_CHG_MV   = 16'h1004; // 4100

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SHIP_DLY_S      = 12;
  localparam int unsigned SHIP_DLY_CYCLES = SHIP_DLY_S * CLK_HZ;

endpackage : cibs_pkg

// file: rtl/cibs_regs.sv
// Input protection, boost and battery switch configuration register bank.
// Assumes a same-clock register port and analog status pins outside.
//
// Functional notes
// (R1) Over-voltage code selects 5.5/6.5/10.5/14 V
// (R2) Boost code selects 4.85/5.00/5.15/5.30 V
// (R3) Regulation threshold is offset plus 100 mV steps
// (R4) Offset select gives 3.9/5.9/7.5/10.5 V
// (R5) Trigger bit starts detection when supply present
// (R6) Trigger bit self-clears when detection completes
// (R7) Half-rate bit slows timer during limiting conditions
// (R8) Disable bit turns battery switch off
// (R9) Delay bit picks immediate or ship-mode-delayed turn-off
// (R10) Warm band limits charge voltage to 4.1 V
// (R11) Reset enable bit permits battery switch reset
// (R12) Tracking code sets battery plus 200-300 mV
// (R13) Effective threshold is larger of both thresholds
// (R14) Register 0x06 powers up as 0xe6
// (R15) Register 0x07 powers up as 0x4c
// (R16) Watchdog restores 0x07 except disable and delay
// (R17) Software reset restores all and resets timer
// (R18) Host must service watchdog before expiry

`timescale 1ns/1ns

module cibs_regs
  import cibs_pkg::*;
#(
  parameter int unsigned SHIP_DLY_CYC = SHIP_DLY_CYCLES
) (
  input  wire logic        MCLK_IN,            // 25 MHz clock
  input  wire logic        RESET_N_IN,         // Async reset, active low
  input  wire logic [7:0]  REG_ADDR_IN,        // Register address
  input  wire logic [7:0]  REG_WDATA_IN,       // Write data
  input  wire logic        REG_WR_IN,          // Write strobe
  input  wire logic        REG_RD_IN,          // Read strobe
  input  wire logic        SW_REG_RESET_IN,    // Software register reset
  input  wire logic        WDOG_EXPIRE_IN,     // Watchdog expiry pulse
  input  wire logic        DETECT_DONE_IN,     // Detection finished pulse
  input  wire logic [1:0]  VINR_OFS_SEL_IN,    // Regulation offset select
  input  wire logic [15:0] VBAT_MV_IN,         // Battery voltage, mV
  input  wire logic [15:0] PROG_CHG_MV_IN,     // Programmed charge volt
  input  wire logic        VBUS_PRESENT_IN,    // Input supply pin
  input  wire logic        DPM_ACTIVE_IN,      // Input power limiting pin
  input  wire logic        COOL_BAT_IN,        // Cool battery pin
  input  wire logic        THERM_REG_IN,       // Thermal regulation pin
  input  wire logic        WARM_BAT_IN,        // Warm battery pin
  output logic      [7:0]  REG_RDATA_OUT,      // Read data
  output logic             REG_RVALID_OUT,     // Read data valid pulse
  output logic      [15:0] OVP_MV_OUT,         // Over-voltage threshold
  output logic      [15:0] BOOST_MV_OUT,       // Boost output voltage
  output logic      [15:0] VINR_MV_OUT,        // Effective regulation
  output logic      [15:0] CHG_MV_OUT,         // Charge voltage limit
  output logic             DETECT_START_OUT,   // Start detection pulse
  output logic             TIMER_HALF_OUT,     // Safety timer half rate
  output logic             TIMER_RESET_OUT,    // Safety timer reset pulse
  output logic             BATSW_ON_OUT,       // Battery switch on
  output logic             BATSW_RST_EN_OUT    // Battery switch reset ok
);

  // ********************************************************************
  // Decoding
  // ********************************************************************
  function automatic logic [15:0] pick4(input logic [1:0] sel,
                                        input logic [15:0] v0,
                                        input logic [15:0] v1,
                                        input logic [15:0] v2,
                                        input logic [15:0] v3);
    case (sel)
      2'h0:    pick4 = v0;
      2'h1:    pick4 = v1;
      2'h2:    pick4 = v2;
      default: pick4 = v3;
    endcase
  endfunction : pick4

  function automatic logic [15:0] max16(input logic [15:0] a,
                                        input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction : max16

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [7:0]  input_protect_boost_dpm_cfg;
    logic [7:0]  timer_battery_switch_cfg;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        det_busy;
    logic        det_start;
    logic        tmr_rst;
    logic [4:0]  pin_s1;
    logic [4:0]  pin_s2;
    logic [31:0] dly_cnt;
    logic        batsw_on;
    logic        half_rate;
    logic [15:0] ovp_mv;
    logic [15:0] boost_mv;
    logic [15:0] vinr_mv;
    logic [15:0] chg_mv;
  } cibs_state_s;

  localparam cibs_state_s STATE_RST = '{
    input_protect_boost_dpm_cfg:    INPUT_PROTECT_BOOST_DPM_CFG_RST,
    timer_battery_switch_cfg:    TIMER_BATTERY_SWITCH_CFG_RST,
    rdata:    UNMAPPED_READ_VALUE,
    rvalid:   1'b0,
    det_busy: 1'b0,
    det_start:1'b0,
    tmr_rst:  1'b0,
    pin_s1:   5'h00,
    pin_s2:   5'h00,
    dly_cnt:  32'h0000_0000,
    batsw_on: 1'b1,
    half_rate:1'b0,
    ovp_mv:   OVP_MV_3,
    boost_mv: BOOST_MV_2,
    vinr_mv:  16'(VINR_OFS_MV_0 + VINR_STEP_MV *
                  INPUT_PROTECT_BOOST_DPM_CFG_RST[VINR_CODE_LSB +: 4]),
    chg_mv:   16'h0000
  };

  cibs_state_s r;
  cibs_state_s n;

  logic        vbus_ok;
  logic        dpm_ok;
  logic        cool_ok;
  logic        therm_ok;
  logic        warm_ok;
  logic        wr06;
  logic        wr07;
  logic [15:0] reg_thr_mv;
  logic [15:0] trk_thr_mv;
  logic [15:0] code_mv;

  assign vbus_ok  = r.pin_s2[0];
  assign dpm_ok   = r.pin_s2[1];
  assign cool_ok  = r.pin_s2[2];
  assign therm_ok = r.pin_s2[3];
  assign warm_ok  = r.pin_s2[4];
  assign wr06 = REG_WR_IN && (REG_ADDR_IN == INPUT_PROTECT_BOOST_DPM_CFG_ADDR);
  assign wr07 = REG_WR_IN && (REG_ADDR_IN == TIMER_BATTERY_SWITCH_CFG_ADDR);

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    n = r;
    n.pin_s1 = {WARM_BAT_IN, THERM_REG_IN, COOL_BAT_IN, DPM_ACTIVE_IN,
                VBUS_PRESENT_IN};
    n.pin_s2 = r.pin_s1;
    n.det_start = 1'b0;
    n.tmr_rst = 1'b0;
    n.rvalid = REG_RD_IN;

    // Detection launch and completion
    if (r.timer_battery_switch_cfg[DETECT_TRIG_BIT] && vbus_ok && !r.det_busy) begin // [R5]
      n.det_start = 1'b1;
      n.det_busy = 1'b1;
    end
    if (DETECT_DONE_IN && r.det_busy) begin // [R6]
      n.timer_battery_switch_cfg[DETECT_TRIG_BIT] = 1'b0;
      n.det_busy = 1'b0;
    end

    // A write lands after the self-clear so a new trigger is not lost
    if (wr06) begin // [R14]
      n.input_protect_boost_dpm_cfg = REG_WDATA_IN;
    end
    if (wr07) begin // [R15]
      n.timer_battery_switch_cfg = REG_WDATA_IN;
    end

    if (SW_REG_RESET_IN) begin // [R17]
      n.input_protect_boost_dpm_cfg = INPUT_PROTECT_BOOST_DPM_CFG_RST;
      n.timer_battery_switch_cfg = TIMER_BATTERY_SWITCH_CFG_RST;
      n.det_busy = 1'b0;
      n.tmr_rst = 1'b1;
    end else if (WDOG_EXPIRE_IN) begin // [R16]
      n.timer_battery_switch_cfg = (r.timer_battery_switch_cfg & WDOG_KEEP_MASK) |
                (TIMER_BATTERY_SWITCH_CFG_RST & ~WDOG_KEEP_MASK);
      n.det_busy = 1'b0;
    end

    // Read data, unmapped addresses read as zero
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        INPUT_PROTECT_BOOST_DPM_CFG_ADDR: n.rdata = r.input_protect_boost_dpm_cfg;
        TIMER_BATTERY_SWITCH_CFG_ADDR:    n.rdata = r.timer_battery_switch_cfg;
        default:                          n.rdata = UNMAPPED_READ_VALUE;
      endcase
    end

    // Battery switch turn-off, counter restarts whenever disable drops
    if (!r.timer_battery_switch_cfg[BATSW_DISABLE_BIT]) begin // [R8]
      n.batsw_on = 1'b1;
      n.dly_cnt = 32'h0000_0000;
    end else if (!r.timer_battery_switch_cfg[BATSW_DLY_BIT]) begin // [R9]
      n.batsw_on = 1'b0;
    end else if (r.dly_cnt >= SHIP_DLY_CYC - 1) begin // [R9]
      n.batsw_on = 1'b0;
    end else begin
      n.dly_cnt = r.dly_cnt + 32'h0000_0001;
    end

    n.half_rate = r.timer_battery_switch_cfg[HALF_RATE_EN_BIT] &&
                  (dpm_ok || cool_ok || therm_ok); // [R7]

    n.ovp_mv = pick4(r.input_protect_boost_dpm_cfg[OVP_SEL_LSB +: 2], OVP_MV_0, OVP_MV_1,
                     OVP_MV_2, OVP_MV_3); // [R1]
    n.boost_mv = pick4(r.input_protect_boost_dpm_cfg[BOOST_SEL_LSB +: 2], BOOST_MV_0,
                       BOOST_MV_1, BOOST_MV_2, BOOST_MV_3); // [R2]
    n.vinr_mv = max16(reg_thr_mv, trk_thr_mv); // [R13]

    if (warm_ok && !r.timer_battery_switch_cfg[WARM_VSEL_BIT]) begin // [R10]
      n.chg_mv = (PROG_CHG_MV_IN < WARM_CHG_MV) ? PROG_CHG_MV_IN
                                                 : WARM_CHG_MV;
    end else begin
      n.chg_mv = PROG_CHG_MV_IN;
    end
  end

  // ********************************************************************
  // Threshold arithmetic
  // ********************************************************************
  // Code is 4 bits so the product stays below 1600 mV
  assign code_mv = 16'(r.input_protect_boost_dpm_cfg[VINR_CODE_LSB +: 4] * VINR_STEP_MV); // [R3]
  assign reg_thr_mv = code_mv + pick4(VINR_OFS_SEL_IN, VINR_OFS_MV_0,
                                      VINR_OFS_MV_1, VINR_OFS_MV_2,
                                      VINR_OFS_MV_3); // [R4]
  // Code 01 is ambiguous; the lower offset is taken
  assign trk_thr_mv = (r.timer_battery_switch_cfg[TRACK_SEL_LSB +: 2] == 2'h0) ? 16'h0000 :
                      VBAT_MV_IN + pick4(r.timer_battery_switch_cfg[TRACK_SEL_LSB +: 2],
                                         16'h0000, TRACK_MV_1,
                                         TRACK_MV_2, TRACK_MV_3); // [R12]

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign REG_RDATA_OUT    = r.rdata;
  assign REG_RVALID_OUT   = r.rvalid;
  assign OVP_MV_OUT       = r.ovp_mv;
  assign BOOST_MV_OUT     = r.boost_mv;
  assign VINR_MV_OUT      = r.vinr_mv;
  assign CHG_MV_OUT       = r.chg_mv;
  assign DETECT_START_OUT = r.det_start;
  assign TIMER_HALF_OUT   = r.half_rate;
  assign TIMER_RESET_OUT  = r.tmr_rst;
  assign BATSW_ON_OUT     = r.batsw_on;
  assign BATSW_RST_EN_OUT = r.timer_battery_switch_cfg[BATSW_RST_EN_BIT]; // [R11]

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_sw_reset_all: assert property ( // [R17]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    SW_REG_RESET_IN |=> (r.input_protect_boost_dpm_cfg == INPUT_PROTECT_BOOST_DPM_CFG_RST) &&
      (r.timer_battery_switch_cfg == TIMER_BATTERY_SWITCH_CFG_RST) && TIMER_RESET_OUT)
    else $error("software reset did not restore defaults");

  chk_wdog_keeps_batsw: assert property ( // [R16]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WDOG_EXPIRE_IN && !SW_REG_RESET_IN) |=>
      (r.timer_battery_switch_cfg[BATSW_DISABLE_BIT] == $past(r.timer_battery_switch_cfg[BATSW_DISABLE_BIT])) &&
      (r.timer_battery_switch_cfg[BATSW_DLY_BIT] == $past(r.timer_battery_switch_cfg[BATSW_DLY_BIT])) &&
      ((r.timer_battery_switch_cfg & ~WDOG_KEEP_MASK) ==
       (TIMER_BATTERY_SWITCH_CFG_RST & ~WDOG_KEEP_MASK)))
    else $error("watchdog reset wrong fields");

  chk_write_input_protect_boost_dpm_cfg: assert property ( // [R14]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (wr06 && !SW_REG_RESET_IN) |=> r.input_protect_boost_dpm_cfg == $past(REG_WDATA_IN))
    else $error("register 0x06 write lost");

  chk_write_timer_battery_switch_cfg: assert property ( // [R15]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (wr07 && !SW_REG_RESET_IN && !WDOG_EXPIRE_IN) |=>
      r.timer_battery_switch_cfg == $past(REG_WDATA_IN))
    else $error("register 0x07 write lost");

  chk_read_timer_battery_switch_cfg: assert property ( // [R15]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (REG_RD_IN && REG_ADDR_IN == TIMER_BATTERY_SWITCH_CFG_ADDR) |=>
      REG_RVALID_OUT && (REG_RDATA_OUT == $past(r.timer_battery_switch_cfg)))
    else $error("register 0x07 read data wrong");

  chk_detect_start: assert property ( // [R5]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $rose(DETECT_START_OUT) |-> $past(vbus_ok) &&
      $past(r.timer_battery_switch_cfg[DETECT_TRIG_BIT]))
    else $error("detection started without trigger and supply");

  chk_detect_clear: assert property ( // [R6]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (DETECT_DONE_IN && r.det_busy && !wr07) |=> !r.timer_battery_switch_cfg[DETECT_TRIG_BIT])
    else $error("trigger bit not cleared after detection");

  chk_batsw_now_off: assert property ( // [R9]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (r.timer_battery_switch_cfg[BATSW_DISABLE_BIT] && !r.timer_battery_switch_cfg[BATSW_DLY_BIT]) |=>
      !BATSW_ON_OUT)
    else $error("immediate turn-off missed");

  chk_batsw_allow_on: assert property ( // [R8]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !r.timer_battery_switch_cfg[BATSW_DISABLE_BIT] |=> BATSW_ON_OUT)
    else $error("switch not allowed on");

  chk_batsw_delay_on: assert property ( // [R9]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (r.timer_battery_switch_cfg[BATSW_DISABLE_BIT] && r.timer_battery_switch_cfg[BATSW_DLY_BIT] &&
     r.dly_cnt < SHIP_DLY_CYC - 2 && $past(!r.timer_battery_switch_cfg[BATSW_DISABLE_BIT]))
    |=> BATSW_ON_OUT)
    else $error("delayed turn-off happened early");

  chk_batsw_delay_off: assert property ( // [R9]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (r.timer_battery_switch_cfg[BATSW_DISABLE_BIT] && r.timer_battery_switch_cfg[BATSW_DLY_BIT] &&
     r.dly_cnt >= SHIP_DLY_CYC - 1) |=> !BATSW_ON_OUT)
    else $error("delayed turn-off missed");

  chk_half_rate: assert property ( // [R7]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    ##1 TIMER_HALF_OUT == $past(r.timer_battery_switch_cfg[HALF_RATE_EN_BIT] &&
                                (dpm_ok || cool_ok || therm_ok)))
    else $error("half rate output wrong");

  chk_vinr_max: assert property ( // [R13]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    ##1 (VINR_MV_OUT >= $past(reg_thr_mv)) &&
        (VINR_MV_OUT >= $past(trk_thr_mv)))
    else $error("effective threshold below a source");

  chk_warm_limit: assert property ( // [R10]
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (warm_ok && !r.timer_battery_switch_cfg[WARM_VSEL_BIT] && $stable(warm_ok)) |=>
      CHG_MV_OUT <= WARM_CHG_MV)
    else $error("warm charge voltage above limit");

endmodule : cibs_regs

// file: verification/cibs_host_model.sv
// Host side model: drives the byte-wide register strobe port.
// Assumes one clock shared with the register bank.
`timescale 1ns/1ns

module cibs_host_model (
  input  wire logic       clk_in,    // Register port clock
  output logic      [7:0] addr_out,  // Register address
  output logic      [7:0] wdata_out, // Write data
  output logic            wr_out,    // Write strobe
  output logic            rd_out     // Read strobe
);
  initial begin
    addr_out = 8'hff;
    wdata_out = 8'hff;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // ******************************************************************
  // Bus cycles
  // ******************************************************************
  // Idle lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
  endtask : rd
endmodule : cibs_host_model

// file: verification/tb_top.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the register port; pins come from here.
`timescale 1ns/1ns

module tb_top;
  import cibs_pkg::*;
  localparam int SD = 20;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, rvalid, sw_rst = 1'b0, wdog = 1'b0, done_p = 1'b0;
  logic [1:0]  ofs = 2'h0;
  logic [15:0] vbat = 16'h0000, prog = 16'h1068;
  logic        vbus = 1'b0, dpm = 1'b0, cool = 1'b0;
  logic        therm = 1'b0, warm = 1'b0;
  logic [15:0] ovp, boost, vinr, chg;
  logic        dstart, half, treset, bat_on, rst_en;
  logic [7:0]  expq[$];
  logic [7:0]  rnd = 8'h40;
  int          err_count = 0, n_compared = 0, n;
  logic [15:0] ovp_t[4] = '{OVP_MV_0, OVP_MV_1, OVP_MV_2, OVP_MV_3};
  logic [15:0] bst_t[4] = '{BOOST_MV_0, BOOST_MV_1, BOOST_MV_2, BOOST_MV_3};
  logic [15:0] ofs_t[4] = '{VINR_OFS_MV_0, VINR_OFS_MV_1, VINR_OFS_MV_2,
                            VINR_OFS_MV_3};
  logic [15:0] trk_t[4] = '{16'h0000, TRACK_MV_1, TRACK_MV_2, TRACK_MV_3};

  always #20 mclk = ~mclk;

  cibs_host_model cibs_host_model_inst (.clk_in(mclk), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  cibs_regs #(.SHIP_DLY_CYC(SD)) cibs_regs_inst (.MCLK_IN(mclk),
    .RESET_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .SW_REG_RESET_IN(sw_rst),
    .WDOG_EXPIRE_IN(wdog), .DETECT_DONE_IN(done_p),
    .VINR_OFS_SEL_IN(ofs), .VBAT_MV_IN(vbat), .PROG_CHG_MV_IN(prog),
    .VBUS_PRESENT_IN(vbus), .DPM_ACTIVE_IN(dpm), .COOL_BAT_IN(cool),
    .THERM_REG_IN(therm), .WARM_BAT_IN(warm), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .OVP_MV_OUT(ovp), .BOOST_MV_OUT(boost),
    .VINR_MV_OUT(vinr), .CHG_MV_OUT(chg), .DETECT_START_OUT(dstart),
    .TIMER_HALF_OUT(half), .TIMER_RESET_OUT(treset),
    .BATSW_ON_OUT(bat_on), .BATSW_RST_EN_OUT(rst_en));

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic bound(input int lim);
    if (n >= lim) begin
      err_count++;
      end_sim();
    end
  endtask : bound

  // Read with its expected byte noted first
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    cibs_host_model_inst.rd(a);
  endtask : rd_exp

  // Derived outputs settle within one cycle, pins within three
  task automatic settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic pulse(input int k);
    @(posedge mclk);
    if (k == 0) sw_rst <= 1'b1;
    if (k == 1) wdog <= 1'b1;
    if (k == 2) done_p <= 1'b1;
    @(posedge mclk);
    sw_rst <= 1'b0;
    wdog <= 1'b0;
    done_p <= 1'b0;
  endtask : pulse

  // Read data checked when its valid pulse appears
  always @(negedge mclk) begin
    if (rvalid === 1'b1) begin
      chk({8'h00, rdata}, {8'h00, expq.pop_front()});
    end
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    rd_exp(INPUT_PROTECT_BOOST_DPM_CFG_ADDR, 8'he6);
    rd_exp(TIMER_BATTERY_SWITCH_CFG_ADDR, 8'h4c);
    chk(ovp, OVP_MV_3);
    chk(boost, BOOST_MV_2);
    chk(vinr, 16'd4500);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      cibs_host_model_inst.wr(8'h06, {i[1:0], i[1:0], rnd[3:0]});
      ofs <= i[1:0];
      settle();
      chk(ovp, ovp_t[i]);
      chk(boost, bst_t[i]);
      chk(vinr, ofs_t[i] + 16'(rnd[3:0]) * VINR_STEP_MV);
    end
    $display("test field_codes done");
    cibs_host_model_inst.wr(8'h06, 8'hf0);
    ofs <= 2'h0;
    vbat <= 16'd5000;
    for (int t = 0; t < 4; t++) begin
      cibs_host_model_inst.wr(8'h07, {6'h13, t[1:0]});
      settle();
      chk(vinr, (t == 0) ? 16'd3900 : 16'd5000 + trk_t[t]);
    end
    @(posedge mclk);
    vbat <= 16'd3000;
    settle();
    chk(vinr, 16'd3900);
    $display("test tracking done");
    @(posedge mclk);
    vbus <= 1'b1;
    cibs_host_model_inst.wr(8'h07, 8'hcc);
    n = 0;
    while (dstart !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    bound(20);
    rd_exp(8'h07, 8'hcc);
    pulse(2);
    settle();
    rd_exp(8'h07, 8'h4c);
    $display("test detection done");
    // Each of the three slow-down conditions on its own
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      {therm, cool, dpm} <= 3'(1 << k);
      settle();
      chk(half, 1'b1);
    end
    cibs_host_model_inst.wr(8'h07, 8'h0c);
    settle();
    chk(half, 1'b0);
    @(posedge mclk);
    warm <= 1'b1;
    settle();
    chk(chg, WARM_CHG_MV);
    cibs_host_model_inst.wr(8'h07, 8'h1c);
    settle();
    chk(chg, prog);
    $display("test timer_warm done");
    cibs_host_model_inst.wr(8'h07, 8'h24);
    settle();
    chk(bat_on, 1'b0);
    cibs_host_model_inst.wr(8'h07, 8'h0c);
    settle();
    chk(bat_on, 1'b1);
    cibs_host_model_inst.wr(8'h07, 8'h2c);
    n = 0;
    while (bat_on !== 1'b0 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    bound(60);
    chk(16'(n >= SD && n <= SD + 6), 16'h1);
    $display("test battery_switch done");
    cibs_host_model_inst.wr(8'h07, 8'h23);
    settle();
    chk(rst_en, 1'b0);
    // Watchdog left unserviced on purpose
    pulse(1);
    settle();
    chk(rst_en, 1'b1);
    rd_exp(8'h07, 8'h64);
    pulse(0);
    n = 0;
    while (treset !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    bound(10);
    rd_exp(8'h06, 8'he6);
    rd_exp(8'h07, 8'h4c);
    cibs_host_model_inst.wr(8'h10, 8'h55);
    rd_exp(8'h10, UNMAPPED_READ_VALUE);
    rd_exp(8'h06, 8'he6);
    settle();
    chk(16'(expq.size()), 16'h0);
    $display("test resets_unmapped done");
    end_sim();
  end
endmodule : tb_top
